// file: design/rmiu_pkg.sv
// Purpose: shared constants and carrier types for the rotate mask insert unit
// Assumes: big-endian bit numbering, bit 0 is the most significant bit
// Notes: register map of the interrupt block is fixed here
package rmiu_pkg;
  localparam int RMIU_DW = 64;
  localparam int RMIU_WW = 32;
  // operation selector
  typedef enum logic [2:0] {
    RMIU_OP_CLR_RIGHT,
    RMIU_OP_CLR_LEFT,
    RMIU_OP_DW_INSERT,
    RMIU_OP_W_INSERT_VAR,
    RMIU_OP_W_INSERT_IMM
  } rmiu_op_t;
  // issue request from the decoder
  typedef struct packed {
    rmiu_op_t op;
    logic [63:0] source_gpr;
    logic [63:0] target_gpr;
    logic [63:0] count_gpr;
    logic [4:0] rotate_count_lo;
    logic rotate_count_hi;
    logic [5:0] mask_begin;
    logic [5:0] mask_end;
    logic record_flag;
    logic summary_ovf;
  } rmiu_req_t;
  // condition field zero: negative, positive, zero, summary overflow
  typedef struct packed {
    logic negative_flag;
    logic positive_flag;
    logic zero_flag;
    logic summary_ovf;
  } rmiu_cr_t;
  // register offsets
  localparam logic [3:0] RMIU_OFS_STATUS = 4'h0;
  localparam logic [3:0] RMIU_OFS_MASK = 4'h4;
  localparam logic [3:0] RMIU_OFS_COUNT = 4'h8;
  // status bit positions
  localparam int RMIU_ST_DONE = 0;
  localparam int RMIU_ST_ILLEGAL = 1;
  localparam logic [1:0] RMIU_MASK_RST = 2'h0;
  localparam logic [15:0] RMIU_COUNT_RST = 16'h0000;
endpackage

// file: design/rmiu_unit.sv
// Purpose: rotate and mask execution unit, doubleword and word forms
// Assumes: one core clock at 50 MHz, decoder holds request fields for the issue cycle
// Notes: result and flags appear one cycle after issue
//
// Behaviour
// [RQ1] clear-right rotates the whole source left by the immediate count
// [RQ2] clear-right mask is ones from bit 0 through mask end
// [RQ3] clear-right result is rotated value AND mask
// [RQ4] doubleword insert mask is ones from mask begin through 63 minus count
// [RQ5] doubleword insert merges rotated bits only where mask is one
// [RQ6] record flag set updates negative, positive, zero, summary overflow
// [RQ7] doubleword forms are illegal on a 32-bit implementation
// [RQ8] variable word insert count is bits 27..31 of the count register
// [RQ9] variable word insert uses a 32-bit mask from begin and end
// [RQ10] word insert takes rotated bit under one, keeps target under zero
// [RQ11] begin below end plus one gives ones from begin through end
// [RQ12] begin equal to end plus one gives an all-ones mask
// [RQ13] begin above end plus one gives a wrapped mask
// [RQ14] word insert never touches exception register or overflow
// [RQ15] immediate word insert rotates by immediate count under mask
// [RQ16] variable word insert is legal only on the legacy variant
// [RQ17] clear-left mask is ones from mask begin through 63
// [RQ18] doubleword count joins five-bit field and extra bit
`timescale 1ns/10ps
`default_nettype none
module rmiu_unit
  import rmiu_pkg::*;
#(
  parameter bit IS_64BIT = 1'b1,
  parameter bit LEGACY_VARIANT = 1'b1
)
(
  input wire logic i_clock, // core clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_valid, // issue strobe
  input wire rmiu_req_t i_req, // operands and fields
  input wire logic [3:0] i_addr, // register address
  input wire logic [31:0] i_wdata, // register write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, one cycle late
  output logic o_irq, // level interrupt
  output logic o_done, // result valid pulse
  output logic [63:0] o_target_gpr, // result value
  output logic o_cr_we, // condition field write pulse
  output rmiu_cr_t o_cond_field_zero, // new condition field
  output logic o_illegal // illegal instruction pulse
);

  // big-endian rotate of a 64-bit value
  function automatic logic [63:0] rot64(input logic [63:0] v, input logic [5:0] n);
    logic [127:0] d;
    d = {v, v} << n;
    return d[127:64];
  endfunction

  // bit i (big-endian) is one when lo <= i <= hi
  function automatic logic [63:0] span64(input logic [5:0] lo, input logic [5:0] hi);
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < 64; i++)
    begin
      m[63 - i] = (6'(i) >= lo) && (6'(i) <= hi);
    end
    return m;
  endfunction

  // word mask with the three begin/end cases
  function automatic logic [31:0] wmask(input logic [4:0] b, input logic [4:0] e);
    logic [31:0] m;
    logic [5:0] e1;
    m = '0;
    e1 = {1'b0, e} + 6'h01;
    for (int i = 0; i < 32; i++)
    begin
      if ({1'b0, b} < e1)
        m[31 - i] = (5'(i) >= b) && (5'(i) <= e); // [RQ11]
      else if ({1'b0, b} == e1)
        m[31 - i] = 1'b1; // [RQ12]
      else
        m[31 - i] = !((5'(i) > e) && (5'(i) < b)); // [RQ13]
    end
    return m;
  endfunction

  // count assembly and operand selection
  wire logic [5:0] dw_count = {i_req.rotate_count_hi, i_req.rotate_count_lo}; // [RQ18]
  wire logic [4:0] var_count = i_req.count_gpr[4:0]; // [RQ8] bits 27..31
  wire logic [4:0] w_count = (i_req.op == RMIU_OP_W_INSERT_VAR) ? var_count : i_req.rotate_count_lo;
  wire logic [31:0] w_src = i_req.source_gpr[31:0];
  wire logic [63:0] w_rot_d = {w_src, w_src} << w_count;
  wire logic [31:0] w_rot = w_rot_d[63:32]; // [RQ15]
  wire logic [63:0] dw_rot = rot64(i_req.source_gpr, dw_count); // [RQ1]
  wire logic [63:0] m_right = span64(6'h00, i_req.mask_end); // [RQ2]
  wire logic [63:0] m_left = span64(i_req.mask_begin, 6'h3F); // [RQ17]
  wire logic [63:0] m_ins = span64(i_req.mask_begin, 6'h3F - dw_count); // [RQ4]
  wire logic [31:0] m_word = wmask(i_req.mask_begin[4:0], i_req.mask_end[4:0]); // [RQ9]
  wire logic is_dw = (i_req.op == RMIU_OP_CLR_RIGHT) || (i_req.op == RMIU_OP_CLR_LEFT)
    || (i_req.op == RMIU_OP_DW_INSERT);
  // 32-bit parts reject doubleword forms; the var form needs the legacy variant
  wire logic illegal = (is_dw && !IS_64BIT) // [RQ7]
    || ((i_req.op == RMIU_OP_W_INSERT_VAR) && !LEGACY_VARIANT) // [RQ16]
    || (i_req.op > RMIU_OP_W_INSERT_IMM);

  // result selection
  logic [63:0] res;
  always_comb
  begin
    res = i_req.target_gpr;
    case (i_req.op)
      RMIU_OP_CLR_RIGHT: res = dw_rot & m_right; // [RQ3]
      RMIU_OP_CLR_LEFT: res = dw_rot & m_left; // [RQ17]
      RMIU_OP_DW_INSERT: res = (dw_rot & m_ins) | (i_req.target_gpr & ~m_ins); // [RQ5]
      RMIU_OP_W_INSERT_VAR,
      RMIU_OP_W_INSERT_IMM: res = {i_req.target_gpr[63:32],
        (w_rot & m_word) | (i_req.target_gpr[31:0] & ~m_word)}; // [RQ10]
      default: res = i_req.target_gpr;
    endcase
  end

  // flags judged on the width the operation produces
  wire logic [63:0] cmp = is_dw ? res : {{32{res[31]}}, res[31:0]};
  wire rmiu_cr_t cr_nxt = '{negative_flag: cmp[63],
    positive_flag: !cmp[63] && (cmp != 64'h0000000000000000),
    zero_flag: cmp == 64'h0000000000000000, summary_ovf: i_req.summary_ovf};
  wire logic go = i_valid && !illegal;

  // result stage; no overflow or exception register output exists at all
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_done <= 1'b0;
      o_target_gpr <= 64'h0000000000000000;
      o_cr_we <= 1'b0;
      o_cond_field_zero <= '0;
      o_illegal <= 1'b0;
    end
    else
    begin
      o_done <= go;
      o_illegal <= i_valid && illegal; // [RQ7]
      o_cr_we <= go && i_req.record_flag; // [RQ6] [RQ14]
      if (go)
        o_target_gpr <= res;
      if (go && i_req.record_flag)
        o_cond_field_zero <= cr_nxt; // [RQ6]
    end
  end

  // status, mask and op counter registers; set wins over write-one clear
  logic [1:0] status_r, mask_r;
  logic [15:0] count_r;
  wire logic [1:0] ev = {i_valid && illegal, go};
  wire logic [1:0] clr = (i_wr && i_addr == RMIU_OFS_STATUS) ? i_wdata[1:0] : 2'h0;
  wire logic [31:0] rd_mux = (i_addr == RMIU_OFS_STATUS) ? {30'h0, status_r}
    : (i_addr == RMIU_OFS_MASK) ? {30'h0, mask_r}
    : (i_addr == RMIU_OFS_COUNT) ? {16'h0000, count_r} : 32'h00000000;
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      status_r <= 2'h0;
      mask_r <= RMIU_MASK_RST;
      count_r <= RMIU_COUNT_RST;
      o_rdata <= 32'h00000000;
      o_irq <= 1'b0;
    end
    else
    begin
      status_r <= (status_r & ~clr) | ev;
      if (i_wr && i_addr == RMIU_OFS_MASK)
        mask_r <= i_wdata[1:0];
      if (go)
        count_r <= count_r + 16'h0001;
      o_rdata <= i_rd ? rd_mux : 32'h00000000;
      o_irq <= |(((status_r & ~clr) | ev) & mask_r);
    end
  end

  // checks
  a_clr_right_result: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && !illegal && i_req.op == RMIU_OP_CLR_RIGHT |=> o_target_gpr == $past(dw_rot & m_right))
    else $error("clear-right result wrong"); // [RQ3]
  a_dw_insert_keep: assert property (@(posedge i_clock) disable iff (i_rst)
    go && i_req.op == RMIU_OP_DW_INSERT |=>
    ((o_target_gpr ^ $past(i_req.target_gpr)) & ~$past(m_ins)) == 64'h0)
    else $error("insert changed unmasked bit"); // [RQ5]
  a_word_keep_high: assert property (@(posedge i_clock) disable iff (i_rst)
    go && i_req.op == RMIU_OP_W_INSERT_VAR |=> o_target_gpr[63:32] == $past(i_req.target_gpr[63:32]))
    else $error("word insert touched high half"); // [RQ10]
  a_full_mask: assert property (@(posedge i_clock) disable iff (i_rst)
    {1'b0, i_req.mask_begin[4:0]} == {1'b0, i_req.mask_end[4:0]} + 6'h01 |-> m_word == 32'hFFFFFFFF)
    else $error("mask not all ones"); // [RQ12]
  a_wrap_mask: assert property (@(posedge i_clock) disable iff (i_rst)
    {1'b0, i_req.mask_begin[4:0]} > {1'b0, i_req.mask_end[4:0]} + 6'h01 |-> m_word[31] && m_word[0])
    else $error("wrapped mask lost ends"); // [RQ13]
  a_cr_record: assert property (@(posedge i_clock) disable iff (i_rst)
    o_cr_we |-> $past(i_req.record_flag) && o_done
    && (o_cond_field_zero.zero_flag == (o_target_gpr == 64'h0) || !$past(is_dw)))
    else $error("condition field update wrong"); // [RQ6]
  a_no_cr_norec: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && !i_req.record_flag |=> !o_cr_we && $stable(o_cond_field_zero))
    else $error("condition field changed without record"); // [RQ14]
  a_dw_illegal_32: assert property (@(posedge i_clock) disable iff (i_rst)
    i_valid && is_dw && !IS_64BIT |=> o_illegal && !o_done)
    else $error("doubleword accepted on 32-bit part"); // [RQ7]
  a_left_mask: assert property (@(posedge i_clock) disable iff (i_rst)
    i_req.mask_begin == 6'h00 |-> m_left == 64'hFFFFFFFFFFFFFFFF && m_right[63])
    else $error("clear-left mask wrong"); // [RQ17]
  c_clr_right: cover property (@(posedge i_clock) go && i_req.op == RMIU_OP_CLR_RIGHT);
  c_w_var_rec: cover property (@(posedge i_clock) go && i_req.op == RMIU_OP_W_INSERT_VAR && i_req.record_flag);
  c_illegal: cover property (@(posedge i_clock) i_valid && illegal);
  c_irq: cover property (@(posedge i_clock) o_irq);

  // the checks below share one clock and one reset, so they lean on defaults
  default clocking cb_core @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  c_dw_insert: cover property (go && i_req.op == RMIU_OP_DW_INSERT && i_req.record_flag);

  // issue answers: exactly one of done or illegal follows each issue
  a_done_follows: assert property ( // [RQ15]
    go |=> o_done && !o_illegal)
    else $error("legal issue gave no done");

  a_done_idle: assert property ( // [RQ15]
    !i_valid |=> !o_done && !o_illegal)
    else $error("answer without issue");

  a_illegal_follows: assert property ( // [RQ7]
    i_valid && illegal |=> o_illegal && !o_done && !o_cr_we)
    else $error("illegal issue not refused");

  a_bad_opcode: assert property ( // [RQ7]
    i_valid && i_req.op > RMIU_OP_W_INSERT_IMM |=> o_illegal)
    else $error("unknown op accepted");

  a_var_legacy: assert property ( // [RQ16]
    i_valid && i_req.op == RMIU_OP_W_INSERT_VAR && !LEGACY_VARIANT |=> o_illegal)
    else $error("variable word insert accepted off legacy");

  a_dw_legal_64: assert property ( // [RQ7]
    i_valid && is_dw && IS_64BIT |=> o_done)
    else $error("doubleword refused on 64-bit part");

  // held outputs only move on a legal issue
  a_result_hold: assert property ( // [RQ10]
    !go |=> $stable(o_target_gpr))
    else $error("result moved without issue");

  a_cr_hold: assert property ( // [RQ14]
    !(go && i_req.record_flag) |=> $stable(o_cond_field_zero))
    else $error("condition field moved without record");

  a_cr_we_rec: assert property ( // [RQ6]
    go && i_req.record_flag |=> o_cr_we)
    else $error("record flag ignored");

  // condition field judged against itself, the stored result and the issued summary bit, not the flag logic
  a_cr_onehot: assert property ( // [RQ6]
    o_cr_we |-> $onehot({o_cond_field_zero.negative_flag, o_cond_field_zero.positive_flag,
      o_cond_field_zero.zero_flag}))
    else $error("condition flags not exclusive");

  a_cr_neg_dw: assert property ( // [RQ6]
    o_cr_we && $past(is_dw) |-> o_cond_field_zero.negative_flag == o_target_gpr[63])
    else $error("doubleword sign flag wrong");

  a_cr_neg_word: assert property ( // [RQ6]
    o_cr_we && !$past(is_dw) |-> o_cond_field_zero.negative_flag == o_target_gpr[31])
    else $error("word sign flag wrong");

  a_cr_zero_word: assert property ( // [RQ6]
    o_cr_we && !$past(is_dw) |-> o_cond_field_zero.zero_flag == (o_target_gpr[31:0] == 32'h00000000))
    else $error("word zero flag wrong");

  a_cr_summary: assert property ( // [RQ6]
    o_cr_we |-> o_cond_field_zero.summary_ovf == $past(i_req.summary_ovf))
    else $error("summary overflow not copied");

  // doubleword results
  a_clr_left_result: assert property ( // [RQ17]
    go && i_req.op == RMIU_OP_CLR_LEFT |=> o_target_gpr == $past(dw_rot & m_left))
    else $error("clear-left result wrong");

  a_clr_left_high: assert property ( // [RQ17]
    go && i_req.op == RMIU_OP_CLR_LEFT |=> (o_target_gpr >> (7'd64 - $past(i_req.mask_begin))) == 64'h0)
    else $error("clear-left kept high bits");

  a_clr_right_low: assert property ( // [RQ2]
    go && i_req.op == RMIU_OP_CLR_RIGHT |=> (o_target_gpr << ($past(i_req.mask_end) + 7'd1)) == 64'h0)
    else $error("clear-right kept low bits");

  a_dw_insert_rot: assert property ( // [RQ5]
    go && i_req.op == RMIU_OP_DW_INSERT |=> ((o_target_gpr ^ $past(dw_rot)) & $past(m_ins)) == 64'h0)
    else $error("insert lost rotated bit");

  // word results: low half under the mask, high half untouched
  a_word_imm_high: assert property ( // [RQ10]
    go && i_req.op == RMIU_OP_W_INSERT_IMM |=> o_target_gpr[63:32] == $past(i_req.target_gpr[63:32]))
    else $error("immediate word insert touched high half");

  a_word_rot_bits: assert property ( // [RQ10]
    go && !is_dw |=> ((o_target_gpr[31:0] ^ $past(w_rot)) & $past(m_word)) == 32'h00000000)
    else $error("word insert lost rotated bit");

  a_word_keep_low: assert property ( // [RQ10]
    go && !is_dw |=> ((o_target_gpr[31:0] ^ $past(i_req.target_gpr[31:0])) & ~$past(m_word)) == 32'h00000000)
    else $error("word insert changed unmasked bit");

  // rotators at their corner counts
  a_rot_zero: assert property ( // [RQ1]
    dw_count == 6'h00 |-> dw_rot == i_req.source_gpr)
    else $error("zero rotate changed source");

  a_rot_one: assert property ( // [RQ1]
    dw_count == 6'h01 |-> dw_rot == {i_req.source_gpr[62:0], i_req.source_gpr[63]})
    else $error("rotate by one wrong");

  a_rot_max: assert property ( // [RQ18]
    dw_count == 6'h3F |-> dw_rot == {i_req.source_gpr[0], i_req.source_gpr[63:1]})
    else $error("rotate by 63 wrong");

  a_rot_half: assert property ( // [RQ18]
    i_req.rotate_count_hi && i_req.rotate_count_lo == 5'h00 |->
    dw_rot == {i_req.source_gpr[31:0], i_req.source_gpr[63:32]})
    else $error("extra count bit ignored");

  a_var_count_zero: assert property ( // [RQ8]
    i_req.op == RMIU_OP_W_INSERT_VAR && i_req.count_gpr[4:0] == 5'h00 |-> w_rot == i_req.source_gpr[31:0])
    else $error("variable zero count rotated");

  a_var_count_one: assert property ( // [RQ8]
    i_req.op == RMIU_OP_W_INSERT_VAR && i_req.count_gpr[4:0] == 5'h01 |->
    w_rot == {i_req.source_gpr[30:0], i_req.source_gpr[31]})
    else $error("variable count taken from wrong bits");

  a_imm_count_half: assert property ( // [RQ15]
    i_req.op == RMIU_OP_W_INSERT_IMM && i_req.rotate_count_lo == 5'h10 |->
    w_rot == {i_req.source_gpr[15:0], i_req.source_gpr[31:16]})
    else $error("immediate word rotate wrong");

  // mask edges at their documented positions
  a_span_ends: assert property ( // [RQ11]
    i_req.mask_begin[4:0] <= i_req.mask_end[4:0] |->
    m_word[31 - i_req.mask_begin[4:0]] && m_word[31 - i_req.mask_end[4:0]])
    else $error("word mask ends missing");

  a_span_before: assert property ( // [RQ11]
    i_req.mask_begin[4:0] != 5'h00 && i_req.mask_begin[4:0] <= i_req.mask_end[4:0] |->
    !m_word[32 - i_req.mask_begin[4:0]])
    else $error("word mask starts early");

  a_wrap_gap: assert property ( // [RQ13]
    {1'b0, i_req.mask_begin[4:0]} > {1'b0, i_req.mask_end[4:0]} + 6'h01 |-> !m_word[30 - i_req.mask_end[4:0]])
    else $error("wrapped mask gap missing");

  a_right_mask_end: assert property ( // [RQ2]
    m_right[6'h3F - i_req.mask_end] && (i_req.mask_end == 6'h3F || !m_right[6'h3E - i_req.mask_end]))
    else $error("clear-right mask end wrong");

  a_ins_mask_end: assert property ( // [RQ4]
    i_req.mask_begin <= 6'h3F - dw_count |-> m_ins[dw_count] && m_ins[6'h3F - i_req.mask_begin])
    else $error("insert mask ends missing");

  a_ins_mask_past: assert property ( // [RQ4]
    dw_count != 6'h00 |-> !m_ins[dw_count - 6'h01])
    else $error("insert mask runs past end");

  // status, interrupt and counter registers
  a_status_done: assert property ( // [RQ15]
    go |=> status_r[RMIU_ST_DONE])
    else $error("done event not recorded");

  a_status_illegal: assert property ( // [RQ7]
    i_valid && illegal |=> status_r[RMIU_ST_ILLEGAL])
    else $error("illegal event not recorded");

  a_status_clear: assert property ( // [RQ15]
    i_wr && i_addr == RMIU_OFS_STATUS && i_wdata[0] && !go |=> !status_r[RMIU_ST_DONE])
    else $error("done bit not cleared");

  a_irq_level: assert property ( // [RQ7]
    o_irq == |(status_r & $past(mask_r)))
    else $error("interrupt level wrong");

  a_rdata_idle: assert property ( // [RQ14]
    !i_rd |=> o_rdata == 32'h00000000)
    else $error("read data without read");

  a_count_step: assert property ( // [RQ15]
    go |=> count_r == $past(count_r) + 16'h0001)
    else $error("op counter missed a step");

  a_count_hold: assert property ( // [RQ7]
    !go |=> $stable(count_r))
    else $error("op counter moved without legal op");
endmodule
`default_nettype wire

// file: sim/rmiu_issue_model.sv
// Purpose: decoder model issuing rotate requests to the unit
// Assumes: requests change right after a rising edge
// Notes: idle fields carry scrambled junk so a late sample shows up
`timescale 1ns/10ps
`default_nettype none
module rmiu_issue_model
  import rmiu_pkg::*;
(
  input wire logic i_clock, // core clock
  output var logic o_valid, // issue strobe
  output var rmiu_req_t o_req // request fields
);
  // quiet at time zero
  initial
  begin
    o_valid = 1'b0;
    o_req = '0;
  end
  // one request per cycle, so back to back issue works
  task automatic issue(input rmiu_req_t r);
    o_valid <= 1'b1;
    o_req <= r;
    @(posedge i_clock);
  endtask
  // gap cycles: fields inverted each cycle, never a stale request
  task automatic idle(input int n);
    repeat (n)
    begin
      o_valid <= 1'b0;
      o_req <= ~o_req;
      @(posedge i_clock);
    end
  endtask
endmodule
`default_nettype wire

// file: sim/test_rotate_mask_insert_unit.sv
// Purpose: self-checking bench for the rotate mask insert unit
// Assumes: 50 MHz clock, async reset held 16 cycles
// Notes: second instance acts as a 32-bit core without the legacy form
`timescale 1ns/10ps
`default_nettype none
module test_rotate_mask_insert_unit
  import rmiu_pkg::*;
;
  typedef struct packed {logic ill; logic alt_ill; logic [63:0] t; logic we; rmiu_cr_t cr;} rmiu_note_t;
  logic i_clock, i_rst, i_valid, i_wr, i_rd, o_irq, o_done, o_cr_we, o_illegal, alt_done, alt_ill;
  logic v_q = 1'b0;
  logic r_q = 1'b0;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [31:0] legal = 32'h0;
  logic [63:0] o_target_gpr;
  rmiu_req_t i_req;
  rmiu_cr_t o_cond_field_zero;
  rmiu_note_t nt;
  rmiu_note_t q[$];
  logic [31:0] rq[$];
  int n_fail = 0;
  int compares = 0;
  int bt[6][2] = '{'{5, 10}, '{11, 10}, '{20, 3}, '{0, 31}, '{31, 0}, '{0, 63}};
  rmiu_issue_model u_dec (.i_clock(i_clock), .o_valid(i_valid), .o_req(i_req));
  rmiu_unit u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_valid(i_valid), .i_req(i_req), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_done(o_done),
    .o_target_gpr(o_target_gpr), .o_cr_we(o_cr_we), .o_cond_field_zero(o_cond_field_zero), .o_illegal(o_illegal));
  rmiu_unit #(.IS_64BIT(1'b0), .LEGACY_VARIANT(1'b0)) u_alt (.i_clock(i_clock), .i_rst(i_rst), .i_valid(i_valid),
    .i_req(i_req), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(), .o_irq(),
    .o_done(alt_done), .o_target_gpr(), .o_cr_we(), .o_cond_field_zero(), .o_illegal(alt_ill));
  // 20 ns clock
  initial
  begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  // mask in big-endian numbering; begin above end wraps round
  function automatic logic [63:0] mk(input int w, b, e);
    mk = '0;
    for (int k = 0; k < w; k++)
      mk[w-1-k] = (b <= e) ? (k >= b && k <= e) : !(k > e && k < b);
  endfunction
  // reference result, flags and legality of one request
  function automatic rmiu_note_t model(input rmiu_req_t r);
    int n;
    logic [63:0] rot, m;
    logic [31:0] w;
    n = {r.rotate_count_hi, r.rotate_count_lo};
    rot = (r.source_gpr << n) | (r.source_gpr >> (64 - n));
    case (r.op)
      RMIU_OP_CLR_RIGHT: m = mk(64, 0, r.mask_end);
      RMIU_OP_CLR_LEFT: m = mk(64, r.mask_begin, 63);
      RMIU_OP_DW_INSERT: m = mk(64, r.mask_begin, 63 - n);
      default: m = mk(32, r.mask_begin[4:0], r.mask_end[4:0]);
    endcase
    if (r.op > RMIU_OP_DW_INSERT)
    begin
      n = (r.op == RMIU_OP_W_INSERT_VAR) ? r.count_gpr[4:0] : r.rotate_count_lo;
      w = r.source_gpr[31:0];
      rot = {32'h0, (w << n) | (w >> (32 - n))};
    end
    model.t = (r.op < RMIU_OP_DW_INSERT) ? rot & m : (rot & m) | (r.target_gpr & ~m);
    model.ill = r.op > RMIU_OP_W_INSERT_IMM;
    model.alt_ill = r.op != RMIU_OP_W_INSERT_IMM;
    model.we = r.record_flag & !model.ill;
    m = (r.op > RMIU_OP_DW_INSERT) ? {{32{model.t[31]}}, model.t[31:0]} : model.t;
    model.cr = {m[63], !m[63] && m != 64'h0, m == 64'h0, r.summary_ovf};
  endfunction
  function automatic logic [63:0] r64();
    return {$urandom, $urandom};
  endfunction
  task automatic check(input string nm, input logic [63:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // note the expectation, then hand the request to the decoder model
  task automatic go(input rmiu_op_t op, input logic [63:0] s, t, c, input logic [5:0] sh, mb, me, input logic rec);
    rmiu_req_t r;
    if (op == RMIU_OP_DW_INSERT)
      sh = 6'(sh % (64 - mb));
    r = '{op, s, t, c, sh[4:0], sh[5], mb, me, rec, 1'($urandom)};
    q.push_back(model(r));
    legal += 32'(op <= RMIU_OP_W_INSERT_IMM);
    u_dec.issue(r);
  endtask
  // one bus cycle, then a gap so strobes never pile up in one step
  task automatic bus(input logic w, r, input logic [3:0] a, input logic [31:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask
  // irq is registered, so give it two edges before looking
  task automatic irq_is(input logic e);
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    check("irq", o_irq, e);
    @(posedge i_clock);
  endtask
  task automatic close_out();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watcher: every answer a cycle after issue pops the oldest note
  always @(posedge i_clock)
  begin
    #1;
    if (v_q)
    begin
      nt = q.pop_front();
      check("illegal", o_illegal, nt.ill);
      check("done", o_done, !nt.ill);
      check("alt_illegal", alt_ill, nt.alt_ill);
      check("alt_done", alt_done, !nt.alt_ill);
      check("cr_write", o_cr_we, nt.we);
      if (!nt.ill)
        check("result", o_target_gpr, nt.t);
      if (nt.we)
        check("cond", o_cond_field_zero, nt.cr);
    end
    if (r_q)
      check("rdata", o_rdata, rq.pop_front());
    v_q = i_valid;
    r_q = i_rd;
  end
  // hang guard
  initial
  begin
    repeat (3000) @(posedge i_clock);
    n_fail++;
    close_out();
  end
  // main sequence
  initial
  begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    void'($urandom(32'h7E77));
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    rdchk(RMIU_OFS_STATUS, 32'h0);
    rdchk(RMIU_OFS_MASK, 32'h0);
    rdchk(RMIU_OFS_COUNT, 32'h0);
    go(RMIU_OP_W_INSERT_IMM, 64'h9000_3000, 64'h3, 64'h0, 6'h2, 6'h0, 6'h1D, 1'b0);
    go(RMIU_OP_W_INSERT_VAR, 64'hB004_3000, 64'hFFFF_FFFF, 64'h2, 6'h0, 6'h0, 6'h1D, 1'b1);
    foreach (bt[i])
      for (int k = 0; k < 5; k++)
        go(rmiu_op_t'(k), r64(), r64(), r64(), 6'($urandom), 6'(bt[i][0]), 6'(bt[i][1]), 1'b1);
    repeat (60)
      go(rmiu_op_t'($urandom % 5), r64(), r64(), r64(), 6'($urandom), 6'($urandom), 6'($urandom), 1'($urandom));
    for (int k = 5; k < 8; k++)
      go(rmiu_op_t'(k), r64(), r64(), r64(), 6'h1, 6'h2, 6'h3, 1'b1);
    u_dec.idle(2);
    bus(1'b1, 1'b0, RMIU_OFS_MASK, 32'h3);
    irq_is(1'b1);
    bus(1'b1, 1'b0, RMIU_OFS_STATUS, 32'h1);
    rdchk(RMIU_OFS_STATUS, 32'h2);
    bus(1'b1, 1'b0, RMIU_OFS_MASK, 32'h1);
    irq_is(1'b0);
    bus(1'b1, 1'b0, RMIU_OFS_STATUS, 32'h2);
    bus(1'b1, 1'b0, RMIU_OFS_COUNT, 32'hFFFF);
    bus(1'b1, 1'b0, 4'hC, 32'hFFFF);
    rdchk(RMIU_OFS_STATUS, 32'h0);
    rdchk(RMIU_OFS_COUNT, legal);
    rdchk(4'hC, 32'h0);
    repeat (2) @(posedge i_clock);
    close_out();
  end
endmodule
`default_nettype wire
